//--- hw/hid_desc_exec.sv
module hid_desc_exec
  import hid_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Microframe start pin
  input  wire logic              uframe_start,
  // Packet engine
  output logic                   pkt_req,
  output logic      [FA_W-1:0]   function_addr,
  output logic      [EP_W-1:0]   endpoint_num,
  output logic      [MPS_W-1:0]  pkt_len,
  input  wire logic              pkt_done,
  input  wire logic [MPS_W-1:0]  pkt_bytes,
  input  wire logic              pkt_fatal
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    hid_state_t        state;
    logic [63:0]       desc;
    logic [TBC_W-1:0]  moved;
    logic [MULT_W-1:0] cnt;
    logic [MULT_W-1:0] exe_mult;
    logic [MPS_W-1:0]  exe_mps;
    logic              fatal;
    logic              done;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              pkt_req;
    logic [FA_W-1:0]   function_addr;
    logic [EP_W-1:0]   endpoint_num;
    logic [MPS_W-1:0]  pkt_len;
  } hid_exec_st_t;

  hid_exec_st_t r;
  hid_exec_st_t next_r;
  logic         tick;
  logic         access;
  logic         wr_lo;
  logic         wr_hi;
  logic         wr_stat;

  hid_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (uframe_start),
    .rise    (tick)
  );

  assign access  = psel & penable & r.pready;
  assign wr_lo   = access & pwrite & (paddr == OFF_DESC_LO);
  assign wr_hi   = access & pwrite & (paddr == OFF_DESC_HI);
  assign wr_stat = access & pwrite & (paddr == OFF_STATUS);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [TBC_W-1:0]  total;
    logic [TBC_W-1:0]  rem;
    logic [TBC_W:0]    sum;
    logic [MPS_W-1:0]  mps;
    logic [MULT_W-1:0] mult;
    logic [31:0]       stat;
    logic              short_pkt;
    logic              issue;
    next_r    = r;
    total     = r.desc[TBC_MSB:TBC_LSB];
    mps       = r.desc[MPS_MSB:MPS_LSB];
    mult      = r.desc[MULT_MSB:MULT_LSB];
    rem       = '0;
    sum       = '0;
    stat      = '0;
    short_pkt = 1'b0;
    issue     = 1'b0;

    // Zero-wait APB: read data sampled in setup, answered in access
    stat[STAT_MOVED_MSB:0] = r.moved;
    stat[STAT_BUSY]        = (r.state == ST_XFER);
    stat[STAT_FATAL]       = r.fatal;
    stat[STAT_DONE]        = r.done;
    next_r.pready  = psel & ~penable;
    next_r.pslverr = 1'b0;
    if (psel & ~penable) begin
      case (paddr)
        OFF_DESC_LO: next_r.prdata = r.desc[HI_BASE-1:0];
        OFF_DESC_HI: next_r.prdata = r.desc[63:HI_BASE];
        OFF_STATUS:  next_r.prdata = stat;
        default: begin
          next_r.prdata  = '0;
          next_r.pslverr = 1'b1;
        end
      endcase
    end

    // Flags cleared first so a same-cycle event still sets them
    if (wr_stat) begin
      if (pwdata[STAT_FATAL]) next_r.fatal = 1'b0;
      if (pwdata[STAT_DONE])  next_r.done  = 1'b0;
    end

    case (r.state)
      ST_IDLE: begin
        // Nothing is issued for an invalid descriptor
        if (tick && r.desc[VALID_BIT]) begin
          if (total == r.moved) begin
            next_r.desc[VALID_BIT] = 1'b0;
            next_r.done            = 1'b1;
          end else begin
            // Zero multiplier is undefined; run it as one packet
            next_r.exe_mult = (mult == MULT_NONE) ? MULT_ONE : mult;
            next_r.exe_mps  = mps;
            next_r.cnt      = '0;
            next_r.state    = ST_XFER;
            issue           = 1'b1;
          end
        end
      end
      ST_XFER: begin
        if (pkt_done) begin
          // One spare bit so a large total cannot wrap before saturating
          sum = {1'b0, r.moved} + (TBC_W+1)'(pkt_bytes);
          next_r.moved = (sum > {1'b0, total}) ?
                         total : sum[TBC_W-1:0];
          next_r.cnt   = r.cnt + MULT_ONE;
          short_pkt    = (pkt_bytes < r.pkt_len);
          next_r.pkt_req = 1'b0;
          if (pkt_fatal) begin
            next_r.desc[VALID_BIT] = 1'b0;
            next_r.fatal = 1'b1;
            next_r.state = ST_IDLE;
          end else if (next_r.moved == total || short_pkt) begin
            next_r.desc[VALID_BIT] = 1'b0;
            next_r.done  = 1'b1;
            next_r.state = ST_IDLE;
          end else if (next_r.cnt == r.exe_mult ||
                       !r.desc[VALID_BIT]) begin
            next_r.state = ST_IDLE;
          end else begin
            issue = 1'b1;
          end
        end
      end
      default: begin
        next_r.state   = ST_IDLE;
        next_r.pkt_req = 1'b0;
      end
    endcase

    if (issue) begin
      rem = total - next_r.moved;
      next_r.pkt_req       = 1'b1;
      next_r.function_addr = r.desc[FA_MSB:FA_LSB];
      next_r.endpoint_num  = {r.desc[EPH_MSB:EPH_LSB],
                              r.desc[EPL_BIT]};
      next_r.pkt_len = (rem < TBC_W'(next_r.exe_mps)) ?
                       rem[MPS_W-1:0] : next_r.exe_mps;
    end

    // Software write last: its set of the valid bit beats a clear
    if (wr_lo) begin
      next_r.desc[HI_BASE-1:0] = pwdata;
      next_r.moved = '0;
    end
    if (wr_hi) begin
      next_r.desc[63:HI_BASE] = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.state    <= ST_IDLE;
      r.desc     <= DESC_RST;
      r.exe_mult <= MULT_ONE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata        = r.prdata;
  assign pready        = r.pready;
  assign pslverr       = r.pslverr;
  assign pkt_req       = r.pkt_req;
  assign function_addr = r.function_addr;
  assign endpoint_num  = r.endpoint_num;
  assign pkt_len       = r.pkt_len;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    r.state == ST_IDLE && tick && r.desc[VALID_BIT] &&
    r.desc[TBC_MSB:TBC_LSB] != r.moved && !wr_lo && !wr_hi;
  endsequence

  sequence s_fatal_ack;
    r.state == ST_XFER && pkt_done && pkt_fatal && !wr_lo;
  endsequence

  property p_addr;
    s_start |=> pkt_req && function_addr == $past(r.desc[FA_MSB:FA_LSB]);
  endproperty
  a_addr: assert property (p_addr) else $error("function address wrong");

  property p_endp;
    s_start |=> endpoint_num ==
      {$past(r.desc[EPH_MSB:EPH_LSB]), $past(r.desc[EPL_BIT])};
  endproperty
  a_endp: assert property (p_endp) else $error("endpoint number wrong");

  property p_mult;
    r.state == ST_XFER |-> r.cnt < r.exe_mult;
  endproperty
  a_mult: assert property (p_mult) else $error("too many packets");

  property p_len;
    pkt_req |-> pkt_len <= r.exe_mps && pkt_len != '0;
  endproperty
  a_len: assert property (p_len) else $error("packet too long");

  property p_total;
    r.moved <= r.desc[TBC_MSB:TBC_LSB] || $past(wr_lo);
  endproperty
  a_total: assert property (p_total) else $error("moved past total");

  property p_fatal;
    s_fatal_ack |=> !r.desc[VALID_BIT] && r.fatal && !pkt_req;
  endproperty
  a_fatal: assert property (p_fatal) else $error("valid kept on fatal");

  property p_complete;
    r.state == ST_XFER && pkt_done && !pkt_fatal && !wr_lo &&
    pkt_bytes >= r.desc[TBC_MSB:TBC_LSB] - r.moved
    |=> !r.desc[VALID_BIT] && r.done ##1 r.state == ST_IDLE;
  endproperty
  a_complete: assert property (p_complete) else $error("valid kept at end");

  property p_skip;
    r.state == ST_IDLE && !r.desc[VALID_BIT] |=> r.state == ST_IDLE && !pkt_req;
  endproperty
  a_skip: assert property (p_skip) else $error("invalid descriptor ran");

endmodule : hid_desc_exec

//--- hw/hid_sync.sv
module hid_sync
  import hid_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and result
  input  wire logic pin,
  output logic      rise
);

  typedef struct packed {
    logic [SYNC_N-1:0] sh;
    logic              lvl;
    logic              rise;
  } hid_sync_st_t;

  hid_sync_st_t r;
  hid_sync_st_t next_r;

  // Stage 0 feeds only stage 1; the level moves once stages 1 and 2 agree
  always_comb begin
    next_r      = r;
    next_r.sh   = {r.sh[SYNC_N-2:0], pin};
    next_r.rise = 1'b0;
    if (r.sh[1] == r.sh[2]) begin
      next_r.lvl  = r.sh[2];
      next_r.rise = r.sh[2] & ~r.lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rise = r.rise;

endmodule : hid_sync

//--- include/hid_pkg.sv
package hid_pkg;

  // ---------------------------------------------------------------
  // Bus and field widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int FA_W   = 7;
  localparam int EP_W   = 4;
  localparam int MULT_W = 2;
  localparam int MPS_W  = 11;
  localparam int TBC_W  = 15;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_DESC_LO = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_DESC_HI = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 12'h008;

  // ---------------------------------------------------------------
  // Descriptor bit map (64-bit view, high word at 63:32)
  // ---------------------------------------------------------------
  localparam int FA_MSB    = 41;
  localparam int FA_LSB    = 35;
  localparam int EPH_MSB   = 34;
  localparam int EPH_LSB   = 32;
  localparam int EPL_BIT   = 31;
  localparam int MULT_MSB  = 30;
  localparam int MULT_LSB  = 29;
  localparam int MPS_MSB   = 28;
  localparam int MPS_LSB   = 18;
  localparam int TBC_MSB   = 17;
  localparam int TBC_LSB   = 3;
  localparam int VALID_BIT = 0;
  localparam int HI_BASE   = 32;

  // ---------------------------------------------------------------
  // Status word layout
  // ---------------------------------------------------------------
  localparam int STAT_MOVED_MSB = 14;
  localparam int STAT_BUSY      = 15;
  localparam int STAT_FATAL     = 16;
  localparam int STAT_DONE      = 17;

  // ---------------------------------------------------------------
  // Reset values and fixed codes
  // ---------------------------------------------------------------
  localparam logic [63:0]       DESC_RST  = 64'h0;
  localparam logic [MULT_W-1:0] MULT_NONE = 2'h0;
  localparam logic [MULT_W-1:0] MULT_ONE  = 2'h1;
  localparam int                SYNC_N    = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } hid_state_t;

endpackage : hid_pkg

//--- sim/hid_desc_exec_test.sv
module hid_desc_exec_test
  import hid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              pclk = 1'b0, presetn = 1'b0, err;
  logic [ADDR_W-1:0] paddr = '0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic              uframe_start = 1'b0, short_pkt = 1'b0, fatal = 1'b0;
  logic [31:0]       pwdata = '0, prdata, q;
  logic              pready, pslverr, pkt_req, pkt_done, pkt_fatal;
  logic [FA_W-1:0]   function_addr;
  logic [EP_W-1:0]   endpoint_num;
  logic [MPS_W-1:0]  pkt_len, pkt_bytes;
  logic [3:0]        delay = 4'h0;
  int                miscompares = 0, check_count = 0;
  int                seed = 32'h6d6ad11e;
  int                fa, ep, mps, tbc, exp_moved, pkts, r;

  always #2 pclk = ~pclk;

  hid_desc_exec DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .uframe_start, .pkt_req,
    .function_addr, .endpoint_num, .pkt_len, .pkt_done, .pkt_bytes,
    .pkt_fatal);
  hid_ep_model ep_model (.pclk, .presetn, .pkt_req, .pkt_len, .pkt_done,
    .pkt_bytes, .pkt_fatal, .delay, .short_pkt, .fatal);

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic e);
    int n;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick();
    int n;
    pkts = 0;
    @(posedge pclk);
    uframe_start <= 1'b1;
    repeat (3) @(posedge pclk);
    uframe_start <= 1'b0;
    n = 0;
    while (pkt_req !== 1'b1 && n < 12) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (pkt_req === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n == 400) begin
      miscompares++;
    end
    repeat (2) @(posedge pclk);
  endtask : tick

  // -------------------------------------------------------------
  // Reference model of each packet
  // -------------------------------------------------------------
  always @(posedge pclk) begin
    if (pkt_req === 1'b1 && pkt_done === 1'b1) begin
      check(function_addr, fa);
      check(endpoint_num, ep);
      check(pkt_len, (tbc - exp_moved < mps) ? tbc - exp_moved : mps);
      exp_moved += pkt_bytes;
      pkts++;
    end
  end

  task automatic run(input int m, input logic sp, input logic ft);
    int k, rem, exp_p, t;
    fa = $random(seed) & 8'h7f;
    ep = $random(seed) & 8'h0f;
    mps = 16 + ($random(seed) & 8'h3f);
    tbc = 1 + ($random(seed) & 8'hff);
    exp_moved = 0;
    short_pkt <= sp;
    fatal <= ft;
    delay <= 4'($random(seed) & 8'h07);
    apb(OFF_STATUS, 1'b1, 32'h30000, q, err);
    apb(OFF_DESC_HI, 1'b1, {22'h0, fa[6:0], ep[3:1]}, q, err);
    apb(OFF_DESC_LO, 1'b1, {ep[0], m[1:0], mps[10:0], tbc[14:0], 3'h1},
        q, err);
    for (t = 0; t < 40; t++) begin
      rem = tbc - exp_moved;
      exp_p = 0;
      for (k = 0; k < m && rem > 0; k++) begin
        exp_p++;
        rem -= (rem < mps) ? rem : mps;
      end
      // A short or failed packet ends the whole descriptor
      if (sp || ft) begin
        exp_p = 1;
      end
      tick();
      check(pkts, exp_p);
      if (sp || ft || exp_moved >= tbc) begin
        break;
      end
    end
    apb(OFF_DESC_LO, 1'b0, 32'h0, q, err);
    check(q[VALID_BIT], 1'b0);
    apb(OFF_STATUS, 1'b0, 32'h0, q, err);
    check(ft ? q[STAT_FATAL] : q[STAT_DONE], 1'b1);
    if (!ft) begin
      check(q[STAT_MOVED_MSB:0], exp_moved);
    end
    tick();
    check(pkts, 0);
  endtask : run

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (r = 0; r < 4; r++) begin
      apb(ADDR_W'(r * 4), 1'b0, 32'h0, q, err);
      check(q, 32'h0);
      check(err, r == 3);
    end
    for (r = 0; r < 12; r++) begin
      run(1 + r % 3, r == 9, r == 10);
    end
    summarize();
  end

  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule : hid_desc_exec_test

//--- sim/hid_ep_model.sv
module hid_ep_model
  import hid_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Packet link
  input  wire logic             pkt_req,
  input  wire logic [MPS_W-1:0] pkt_len,
  output logic                  pkt_done,
  output logic      [MPS_W-1:0] pkt_bytes,
  output logic                  pkt_fatal,
  // Behaviour control
  input  wire logic [3:0]       delay,
  input  wire logic             short_pkt,
  input  wire logic             fatal
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;

  // -------------------------------------------------------------
  // Endpoint answer
  // -------------------------------------------------------------
  // Outside a completion the data lines toggle, so stale use shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      pkt_done <= 1'b0;
      pkt_bytes <= '0;
      pkt_fatal <= 1'b0;
    end else if (pkt_req && !pkt_done && cnt == delay) begin
      pkt_done <= 1'b1;
      pkt_bytes <= short_pkt ? pkt_len - 11'h1 : pkt_len;
      pkt_fatal <= fatal;
      cnt <= 4'h0;
    end else begin
      pkt_done <= 1'b0;
      pkt_bytes <= ~pkt_bytes;
      pkt_fatal <= ~pkt_fatal;
      cnt <= (pkt_req && !pkt_done) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : hid_ep_model
